// [design/psw_pkg.sv]
// package: constants and types for the regulator limit and sleep/wake control block
package psw_pkg;
  // frequencies in 0.1 Hz units, signed 16 bit
  localparam logic signed [15:0] LOW_LIMIT_RST = 16'sh0000; // 0.0 Hz
  localparam logic signed [15:0] HIGH_LIMIT_RST = 16'sh0258; // 60.0 Hz
  localparam logic [15:0] ERR_WARN_RST = 16'h0064; // 100
  localparam logic [15:0] ACCEL_TIME_RST = 16'h01F4; // 5.00 s in 10 ms units
  localparam logic [15:0] SLEEP_DELAY_RST = 16'h0014; // 20 s
  localparam logic signed [15:0] STARTUP_REF_RST = 16'sh0000;
  // one second tick
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ * TICK_S;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LIMITS = 8'h04;
  localparam logic [7:0] A_ERRWARN = 8'h08;
  localparam logic [7:0] A_SLEEP = 8'h0C;
  localparam logic [7:0] A_BOOST = 8'h10;
  localparam logic [7:0] A_WAKE = 8'h14;
  localparam logic [7:0] A_START = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_RAMP = 8'h20;
  // sleep detect modes
  localparam logic [2:0] SLP_NONE = 3'h0;
  localparam logic [2:0] SLP_SWITCH = 3'h1;
  localparam logic [2:0] SLP_SPEED = 3'h2;
  localparam logic [2:0] SLP_POWER = 3'h3;
  localparam logic [2:0] SLP_MULTI = 3'h4;
  // source select: 0 none, 1..16 digital input, 17..32 command bit
  localparam logic [5:0] SRC_NONE = 6'h00;
  localparam logic [5:0] SRC_DI_BASE = 6'h01;
  localparam logic [5:0] SRC_CMD_BASE = 6'h11;
  localparam logic [5:0] SRC_LAST = 6'h20;
  typedef enum logic [4:0] {
    PSW_IDLE = 5'b00001,
    PSW_RUN = 5'b00010,
    PSW_BOOST = 5'b00100,
    PSW_SLEEP = 5'b01000,
    PSW_MANUAL = 5'b10000
  } psw_state_e;
  typedef struct packed {
    logic signed [15:0] feedback;
    logic signed [15:0] reference;
    logic signed [15:0] reg_out;
    logic signed [15:0] out_freq;
    logic [15:0] out_power;
    logic [15:0] error_mag;
  } psw_proc_s;
endpackage

// [design/psw_ctrl.sv]
// regulator output limiting and sleep/wake-up control with apb registers
// Notes on behaviour
// - regulator output clamped to a low limit, may be negative, default 0 Hz.
// - regulator output clamped to a non-negative high limit, default 60 Hz.
// - error warning set while error exceeds threshold, default 100, max 65535.
// - integral shunt source at 1 disables integral; at 0 integral enabled.
// - shunt source selectable: none by default, digital input or command bit.
// - start ramp used up to low speed instead of regulator ramp, default 0 (off); regulator ramp default 5.00 s.
// - startup reference below low speed is ignored; default 0 Hz.
// - from regulation, sleep entered only without wake condition and sleep condition beyond delay.
// - speed mode: sleep condition while output frequency non-negative and below sleep speed.
// - power mode: sleep condition while output power below sleep power.
// - multiple mode ORs conditions; switch mode uses the switch input.
// - regulator mode needs regulator configured, channel 1 and automatic.
// - feedback wake, direct: wake when feedback below wake level.
// - feedback wake, reverse: wake when feedback above wake level.
// - error wake, direct: wake when feedback below reference minus margin.
// - error wake, reverse: wake when feedback above reference plus margin.
// - entering sleep boosts to boost speed for boost time, then stops.
// - boost time zero skips boost and stops directly.
// - run order in auto starts regulation if waking or sleep mode not configured, else sleeps without boost.
// - switch to auto while running keeps running in regulation, no sleep.
// - sleep switch source selectable as none, digital input or command bit.
// - sleep delay in seconds, default 20 s.
// - sleep mode defaults to not configured, function inactive.
// - wake mode defaults to feedback level.
module psw_ctrl #(
  parameter int unsigned TICK_CYCLES = psw_pkg::TICK_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] digital_in,
  input wire logic [15:0] command_bits,
  input wire logic run_order,
  input wire logic channel1_sel,
  input wire logic auto_mode,
  input wire psw_pkg::psw_proc_s proc,
  output logic signed [15:0] freq_cmd,
  output logic motor_run,
  output logic regulator_active,
  output logic integral_enable,
  output logic error_warning,
  output logic start_ramp_active,
  output logic [15:0] accel_time_sel
);
  // configuration registers
  logic regulator_configured_q;
  logic regulator_inversion_q;
  logic wake_select_q; // 0 feedback, 1 error
  logic [2:0] sleep_detect_select_q;
  logic [5:0] integral_shunt_source_q;
  logic [5:0] sleep_switch_source_q;
  logic signed [15:0] regulator_output_low_limit_q;
  logic signed [15:0] regulator_output_high_limit_q;
  logic [15:0] regulator_error_warning_level_q;
  logic [15:0] sleep_delay_time_q;
  logic [15:0] sleep_speed_level_q;
  logic [15:0] sleep_power_level_q;
  logic signed [15:0] sleep_boost_speed_q;
  logic [15:0] sleep_boost_time_q;
  logic signed [15:0] wake_process_level_q;
  logic [15:0] wake_error_margin_q;
  logic signed [15:0] startup_speed_reference_q;
  logic signed [15:0] low_speed_setting_q;
  logic [15:0] regulator_accel_time_q;
  logic [15:0] start_accel_ramp_q;

  // pin synchronisers
  logic [15:0] di_s1_q, di_s2_q, cmd_s1_q, cmd_s2_q;
  logic [2:0] ctl_s1_q, ctl_s2_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      di_s1_q <= 16'h0000;
      di_s2_q <= 16'h0000;
      cmd_s1_q <= 16'h0000;
      cmd_s2_q <= 16'h0000;
      ctl_s1_q <= 3'h0;
      ctl_s2_q <= 3'h0;
    end
    else
    begin
      di_s1_q <= digital_in;
      di_s2_q <= di_s1_q;
      cmd_s1_q <= command_bits;
      cmd_s2_q <= cmd_s1_q;
      ctl_s1_q <= {run_order, channel1_sel, auto_mode};
      ctl_s2_q <= ctl_s1_q;
    end
  end

  // source decode shared by integral shunt and sleep switch
  function automatic logic src_level(input logic [5:0] sel, input logic [15:0] di,
                                     input logic [15:0] cmd);
    logic [5:0] idx;
    idx = 6'h00;
    src_level = 1'b0;
    if (sel >= psw_pkg::SRC_CMD_BASE && sel <= psw_pkg::SRC_LAST)
    begin
      idx = sel - psw_pkg::SRC_CMD_BASE;
      src_level = cmd[idx[3:0]];
    end
    else if (sel >= psw_pkg::SRC_DI_BASE && sel < psw_pkg::SRC_CMD_BASE)
    begin
      idx = sel - psw_pkg::SRC_DI_BASE;
      src_level = di[idx[3:0]];
    end
  endfunction

  logic shunt_lvl, switch_lvl, run_s, auto_s;
  assign shunt_lvl = src_level(integral_shunt_source_q, di_s2_q, cmd_s2_q);
  assign switch_lvl = src_level(sleep_switch_source_q, di_s2_q, cmd_s2_q);
  assign run_s = ctl_s2_q[2];
  assign auto_s = regulator_configured_q & ctl_s2_q[1] & ctl_s2_q[0];

  // sleep condition
  logic cond_speed, cond_power, cond_switch, sleep_cond;
  assign cond_speed = $signed({1'b0, proc.out_freq[14:0]})
                      < $signed({1'b0, sleep_speed_level_q[14:0]})
                      && !proc.out_freq[15];
  assign cond_power = proc.out_power < sleep_power_level_q;
  assign cond_switch = (sleep_switch_source_q != psw_pkg::SRC_NONE) & switch_lvl;
  always_comb
  begin
    sleep_cond = 1'b0;
    case (sleep_detect_select_q)
      psw_pkg::SLP_SWITCH: sleep_cond = cond_switch;
      psw_pkg::SLP_SPEED: sleep_cond = cond_speed;
      psw_pkg::SLP_POWER: sleep_cond = cond_power;
      psw_pkg::SLP_MULTI: sleep_cond = cond_switch | cond_speed | cond_power;
      default: sleep_cond = 1'b0;
    endcase
  end

  // wake condition
  logic signed [16:0] wake_thr;
  logic wake_cond;
  always_comb
  begin
    if (!wake_select_q)
      wake_thr = {wake_process_level_q[15], wake_process_level_q};
    else if (regulator_inversion_q)
      wake_thr = {proc.reference[15], proc.reference}
                 + $signed({1'b0, wake_error_margin_q});
    else
      wake_thr = {proc.reference[15], proc.reference}
                 - $signed({1'b0, wake_error_margin_q});
    if (regulator_inversion_q)
      wake_cond = $signed({proc.feedback[15], proc.feedback}) > wake_thr;
    else
      wake_cond = $signed({proc.feedback[15], proc.feedback}) < wake_thr;
  end

  // one second tick and counters
  logic [31:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_q <= 32'h0000_0000;
    else if (tick)
      tick_cnt_q <= 32'h0000_0000;
    else
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  end

  psw_pkg::psw_state_e state_q;
  logic [15:0] delay_cnt_q, boost_cnt_q;
  logic delay_done, sleep_fn_on, run_prev_q, auto_prev_q;
  assign sleep_fn_on = (sleep_detect_select_q != psw_pkg::SLP_NONE);
  assign delay_done = sleep_cond && !wake_cond && delay_cnt_q >= sleep_delay_time_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      delay_cnt_q <= 16'h0000;
    else if (state_q != psw_pkg::PSW_RUN || !sleep_cond || wake_cond)
      delay_cnt_q <= 16'h0000;
    else if (tick && delay_cnt_q != 16'hFFFF)
      delay_cnt_q <= delay_cnt_q + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boost_cnt_q <= 16'h0000;
    else if (state_q != psw_pkg::PSW_BOOST)
      boost_cnt_q <= 16'h0000;
    else if (tick)
      boost_cnt_q <= boost_cnt_q + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_prev_q <= 1'b0;
      auto_prev_q <= 1'b0;
    end
    else
    begin
      run_prev_q <= run_s;
      auto_prev_q <= auto_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= psw_pkg::PSW_IDLE;
    else if (!run_s)
      state_q <= psw_pkg::PSW_IDLE;
    else
    begin
      case (state_q)
        psw_pkg::PSW_IDLE:
          if (!auto_s)
            state_q <= psw_pkg::PSW_MANUAL;
          else if (wake_cond || !sleep_fn_on)
            state_q <= psw_pkg::PSW_RUN;
          else
            state_q <= psw_pkg::PSW_SLEEP;
        psw_pkg::PSW_MANUAL:
          if (auto_s)
            state_q <= psw_pkg::PSW_RUN;
        psw_pkg::PSW_RUN:
          if (!auto_s)
            state_q <= psw_pkg::PSW_MANUAL;
          else if (sleep_fn_on && delay_done)
            state_q <= (sleep_boost_time_q == 16'h0000) ? psw_pkg::PSW_SLEEP
                                                         : psw_pkg::PSW_BOOST;
        psw_pkg::PSW_BOOST:
          if (!auto_s)
            state_q <= psw_pkg::PSW_MANUAL;
          else if (boost_cnt_q >= sleep_boost_time_q)
            state_q <= psw_pkg::PSW_SLEEP;
        psw_pkg::PSW_SLEEP:
          if (!auto_s)
            state_q <= psw_pkg::PSW_MANUAL;
          else if (wake_cond || !sleep_fn_on)
            state_q <= psw_pkg::PSW_RUN;
        default:
          state_q <= psw_pkg::PSW_IDLE;
      endcase
    end
  end

  // output limiting and ramp selection
  logic signed [15:0] clamped;
  always_comb
  begin
    clamped = proc.reg_out;
    if (proc.reg_out > regulator_output_high_limit_q)
      clamped = regulator_output_high_limit_q;
    if (proc.reg_out < regulator_output_low_limit_q)
      clamped = regulator_output_low_limit_q;
  end
  logic startup_ok, below_low;
  assign startup_ok = startup_speed_reference_q >= low_speed_setting_q;
  assign below_low = proc.out_freq < low_speed_setting_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_cmd <= 16'sh0000;
      motor_run <= 1'b0;
      regulator_active <= 1'b0;
      integral_enable <= 1'b1;
      error_warning <= 1'b0;
      start_ramp_active <= 1'b0;
      accel_time_sel <= psw_pkg::ACCEL_TIME_RST;
    end
    else
    begin
      regulator_active <= (state_q == psw_pkg::PSW_RUN);
      motor_run <= (state_q == psw_pkg::PSW_RUN) || (state_q == psw_pkg::PSW_BOOST)
                   || (state_q == psw_pkg::PSW_MANUAL);
      if (state_q == psw_pkg::PSW_BOOST)
        freq_cmd <= sleep_boost_speed_q;
      else if (state_q == psw_pkg::PSW_RUN)
        freq_cmd <= (below_low && startup_ok) ? startup_speed_reference_q : clamped;
      else if (state_q == psw_pkg::PSW_MANUAL)
        freq_cmd <= clamped;
      else
        freq_cmd <= 16'sh0000;
      integral_enable <= !shunt_lvl;
      error_warning <= proc.error_mag > regulator_error_warning_level_q;
      // start ramp only while climbing to low speed
      start_ramp_active <= (start_accel_ramp_q != 16'h0000) && below_low;
      accel_time_sel <= ((start_accel_ramp_q != 16'h0000) && below_low) ? start_accel_ramp_q
                                                                        : regulator_accel_time_q;
    end
  end

  // apb slave, zero wait states
  logic wr_en;
  assign wr_en = psel & penable & pwrite;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      regulator_configured_q <= 1'b0;
      regulator_inversion_q <= 1'b0;
      wake_select_q <= 1'b0;
      sleep_detect_select_q <= psw_pkg::SLP_NONE;
      integral_shunt_source_q <= psw_pkg::SRC_NONE;
      sleep_switch_source_q <= psw_pkg::SRC_NONE;
      regulator_output_low_limit_q <= psw_pkg::LOW_LIMIT_RST;
      regulator_output_high_limit_q <= psw_pkg::HIGH_LIMIT_RST;
      regulator_error_warning_level_q <= psw_pkg::ERR_WARN_RST;
      sleep_delay_time_q <= psw_pkg::SLEEP_DELAY_RST;
      sleep_speed_level_q <= 16'h0000;
      sleep_power_level_q <= 16'h0000;
      sleep_boost_speed_q <= 16'sh0000;
      sleep_boost_time_q <= 16'h0000;
      wake_process_level_q <= 16'sh0000;
      wake_error_margin_q <= 16'h0000;
      startup_speed_reference_q <= psw_pkg::STARTUP_REF_RST;
      low_speed_setting_q <= 16'sh0000;
      regulator_accel_time_q <= psw_pkg::ACCEL_TIME_RST;
      start_accel_ramp_q <= 16'h0000;
    end
    else if (wr_en)
    begin
      if (paddr == psw_pkg::A_CTRL)
      begin
        regulator_configured_q <= pwdata[0];
        regulator_inversion_q <= pwdata[1];
        wake_select_q <= pwdata[2];
        sleep_detect_select_q <= pwdata[6:4];
        integral_shunt_source_q <= pwdata[13:8];
        sleep_switch_source_q <= pwdata[21:16];
      end
      else if (paddr == psw_pkg::A_LIMITS)
      begin
        regulator_output_low_limit_q <= pwdata[15:0];
        // high limit is non-negative
        regulator_output_high_limit_q <= pwdata[31] ? 16'sh0000 : pwdata[31:16];
      end
      else if (paddr == psw_pkg::A_ERRWARN)
        regulator_error_warning_level_q <= pwdata[15:0];
      else if (paddr == psw_pkg::A_SLEEP)
      begin
        sleep_delay_time_q <= pwdata[15:0];
        sleep_speed_level_q <= {8'h00, pwdata[23:16]} << 4;
        sleep_power_level_q <= {8'h00, pwdata[31:24]} << 4;
      end
      else if (paddr == psw_pkg::A_BOOST)
      begin
        sleep_boost_speed_q <= pwdata[15:0];
        sleep_boost_time_q <= pwdata[31:16];
      end
      else if (paddr == psw_pkg::A_WAKE)
      begin
        wake_process_level_q <= pwdata[15:0];
        wake_error_margin_q <= pwdata[31:16];
      end
      else if (paddr == psw_pkg::A_START)
      begin
        startup_speed_reference_q <= pwdata[15:0];
        low_speed_setting_q <= pwdata[31:16];
      end
      else if (paddr == psw_pkg::A_RAMP)
      begin
        regulator_accel_time_q <= pwdata[15:0];
        start_accel_ramp_q <= pwdata[31:16];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel & !penable)
      begin
        if (paddr == psw_pkg::A_CTRL)
          prdata <= {10'h000, sleep_switch_source_q, 2'h0, integral_shunt_source_q, 1'b0,
                     sleep_detect_select_q, 1'b0, wake_select_q, regulator_inversion_q,
                     regulator_configured_q};
        else if (paddr == psw_pkg::A_LIMITS)
          prdata <= {regulator_output_high_limit_q, regulator_output_low_limit_q};
        else if (paddr == psw_pkg::A_ERRWARN)
          prdata <= {16'h0000, regulator_error_warning_level_q};
        else if (paddr == psw_pkg::A_SLEEP)
          prdata <= {sleep_power_level_q[11:4], sleep_speed_level_q[11:4], sleep_delay_time_q};
        else if (paddr == psw_pkg::A_BOOST)
          prdata <= {sleep_boost_time_q, sleep_boost_speed_q};
        else if (paddr == psw_pkg::A_WAKE)
          prdata <= {wake_error_margin_q, wake_process_level_q};
        else if (paddr == psw_pkg::A_START)
          prdata <= {low_speed_setting_q, startup_speed_reference_q};
        else if (paddr == psw_pkg::A_STATUS)
          prdata <= {21'h000000, error_warning, integral_enable, regulator_active, motor_run,
                     wake_cond, sleep_cond, state_q};
        else if (paddr == psw_pkg::A_RAMP)
          prdata <= {start_accel_ramp_q, regulator_accel_time_q};
        else
          pslverr <= 1'b1;
      end
    end
  end

  // checks
  sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(state_q) == psw_pkg::PSW_RUN && state_q == psw_pkg::PSW_BOOST)
    |-> $past(sleep_cond) && !$past(wake_cond))
    else $error("sleep entered without condition");
  boost_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == psw_pkg::PSW_BOOST) |-> sleep_boost_time_q != 16'h0000)
    else $error("boost with zero time");
  clamp_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(state_q) == psw_pkg::PSW_MANUAL) |-> freq_cmd <= $past(regulator_output_high_limit_q))
    else $error("output above high limit");
  clamp_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(state_q) == psw_pkg::PSW_MANUAL) |-> freq_cmd >= $past(regulator_output_low_limit_q))
    else $error("output below low limit");
  err_warn_a: assert property (@(posedge pclk) disable iff (!presetn)
    error_warning == ($past(proc.error_mag) > $past(regulator_error_warning_level_q)))
    else $error("error warning mismatch");
  shunt_a: assert property (@(posedge pclk) disable iff (!presetn)
    integral_enable == !$past(shunt_lvl))
    else $error("integral shunt mismatch");
  timer_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sleep_cond |=> delay_cnt_q == 16'h0000)
    else $error("sleep timer kept running");
  sleep_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sleep_fn_on |-> state_q != psw_pkg::PSW_BOOST)
    else $error("boost with sleep disabled");
endmodule // psw_ctrl

// [verification/psw_plant.sv]
// pump and feedback sensor model: speed and power follow the command
module psw_plant (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic signed [15:0] freq_cmd,
  input wire logic motor_run,
  input wire logic signed [15:0] fb,
  input wire logic signed [15:0] ref_val,
  input wire logic signed [15:0] reg_val,
  input wire logic [15:0] err_val,
  output psw_pkg::psw_proc_s proc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] spd_q;
  logic [15:0] pwr_q;
  // shaft lags the command by a cycle; a halted motor draws no power
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spd_q <= 16'sh0000;
      pwr_q <= 16'h0000;
    end
    else
    begin
      spd_q <= motor_run ? freq_cmd : 16'sh0000;
      pwr_q <= motor_run ? 16'(freq_cmd) : 16'h0000;
    end
  end
  assign proc = '{fb, ref_val, reg_val, spd_q, pwr_q, err_val};
endmodule // psw_plant

// [verification/tb.sv]
// self-checking bench for the regulator limit and sleep/wake block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, motor_run, regulator_active, integral_enable, error_warning;
  logic start_ramp_active;
  logic [15:0] digital_in = 16'h0000;
  logic [15:0] command_bits = 16'h0000;
  logic run_order = 1'b0;
  logic channel1_sel = 1'b0;
  logic auto_mode = 1'b0;
  psw_pkg::psw_proc_s proc;
  logic signed [15:0] freq_cmd;
  logic [15:0] accel_time_sel;
  logic signed [15:0] fb = 16'sh0000;
  logic signed [15:0] ref_val = 16'sh0000;
  logic signed [15:0] reg_val = 16'sh0000;
  logic [15:0] err_val = 16'h0000;
  logic [31:0] rd;
  logic er;
  int mismatches = 0;
  int checks = 0;
  always #4 pclk = ~pclk;
  psw_ctrl #(.TICK_CYCLES(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .digital_in(digital_in), .command_bits(command_bits),
    .run_order(run_order), .channel1_sel(channel1_sel), .auto_mode(auto_mode), .proc(proc),
    .freq_cmd(freq_cmd), .motor_run(motor_run), .regulator_active(regulator_active),
    .integral_enable(integral_enable), .error_warning(error_warning),
    .start_ramp_active(start_ramp_active), .accel_time_sel(accel_time_sel));
  psw_plant plant (.pclk(pclk), .presetn(presetn), .freq_cmd(freq_cmd), .motor_run(motor_run),
    .fb(fb), .ref_val(ref_val), .reg_val(reg_val), .err_val(err_val), .proc(proc));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one edge passes first so psel is never assigned twice in a time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      check("pready", 32'h0, 32'h1);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return motor_run;
      1: return regulator_active;
      2: return integral_enable;
      3: return error_warning;
      default: return freq_cmd === 16'sd50;
    endcase
  endfunction
  task automatic await(input string name, input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    check(name, {31'h0, pick(s)}, {31'h0, v});
  endtask
  task automatic t_reset;
    check("ienable", {31'h0, integral_enable}, 32'h1);
    check("accel", {16'h0, accel_time_sel}, {16'h0, psw_pkg::ACCEL_TIME_RST});
    apb(1'b0, psw_pkg::A_LIMITS, 32'h0);
    check("limits", rd, {psw_pkg::HIGH_LIMIT_RST, psw_pkg::LOW_LIMIT_RST});
    apb(1'b0, psw_pkg::A_ERRWARN, 32'h0);
    check("warn", rd, {16'h0, psw_pkg::ERR_WARN_RST});
    apb(1'b0, psw_pkg::A_SLEEP, 32'h0);
    check("delay", {16'h0, rd[15:0]}, {16'h0, psw_pkg::SLEEP_DELAY_RST});
    apb(1'b0, psw_pkg::A_CTRL, 32'h0);
    check("mode", {29'h0, rd[6:4]}, {29'h0, psw_pkg::SLP_NONE});
    check("wake", {31'h0, rd[2]}, 32'h0);
    check("shunt", {26'h0, rd[13:8]}, {26'h0, psw_pkg::SRC_NONE});
    check("swsrc", {26'h0, rd[21:16]}, {26'h0, psw_pkg::SRC_NONE});
    apb(1'b0, 8'h40, 32'h0);
    check("slverr", {31'h0, er}, 32'h1);
    check("slv_rd", rd, 32'h0);
    apb(1'b1, psw_pkg::A_RAMP, 32'h0064_01F4);
    apb(1'b1, psw_pkg::A_START, 32'h0032_0000);
    repeat (3) @(posedge pclk);
    check("ramp_on", {31'h0, start_ramp_active}, 32'h1);
    check("ramp_sel", {16'h0, accel_time_sel}, 32'h0000_0064);
    apb(1'b1, psw_pkg::A_START, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    check("ramp_off", {31'h0, start_ramp_active}, 32'h0);
  endtask
  task automatic t_warn;
    apb(1'b1, psw_pkg::A_ERRWARN, 32'h0000_0064);
    err_val <= 16'h0064;
    repeat (4) @(posedge pclk);
    check("warn_eq", {31'h0, error_warning}, 32'h0);
    err_val <= 16'h0065;
    await("warn_hi", 3, 1'b1, 6);
    err_val <= 16'h0064;
    await("warn_clr", 3, 1'b0, 6);
  endtask
  task automatic t_shunt;
    apb(1'b1, psw_pkg::A_CTRL, 32'h0000_0100);
    digital_in <= 16'h0001;
    await("shunt_di", 2, 1'b0, 8);
    digital_in <= 16'h0000;
    await("shunt_off", 2, 1'b1, 8);
    apb(1'b1, psw_pkg::A_CTRL, 32'h0000_1400);
    command_bits <= 16'h0008;
    await("shunt_cmd", 2, 1'b0, 8);
    command_bits <= 16'h0000;
  endtask
  task automatic t_run;
    apb(1'b1, psw_pkg::A_LIMITS, 32'h0064_000A);
    apb(1'b1, psw_pkg::A_CTRL, 32'h0000_0001);
    reg_val <= 16'sd200;
    run_order <= 1'b1;
    auto_mode <= 1'b1;
    await("run", 0, 1'b1, 20);
    repeat (10) @(posedge pclk);
    check("no_ch1", {31'h0, regulator_active}, 32'h0);
    channel1_sel <= 1'b1;
    await("auto", 1, 1'b1, 20);
    check("kept", {31'h0, motor_run}, 32'h1);
    repeat (4) @(posedge pclk);
    check("hi_clamp", 32'(freq_cmd), 32'h0000_0064);
    reg_val <= -16'sd50;
    repeat (5) @(posedge pclk);
    check("lo_clamp", 32'(freq_cmd), 32'h0000_000A);
    run_order <= 1'b0;
    await("stop", 0, 1'b0, 20);
  endtask
  task automatic t_switch;
    apb(1'b1, psw_pkg::A_SLEEP, 32'h0000_0002);
    apb(1'b1, psw_pkg::A_BOOST, 32'h0001_0032);
    apb(1'b1, psw_pkg::A_WAKE, 32'h0014_0064);
    apb(1'b1, psw_pkg::A_CTRL, 32'h0002_0011);
    fb <= 16'sd50;
    reg_val <= 16'sd80;
    run_order <= 1'b1;
    await("woke", 1, 1'b1, 20);
    fb <= 16'sd500;
    digital_in <= 16'h0002;
    repeat (10) @(posedge pclk);
    digital_in <= 16'h0000;
    repeat (4) @(posedge pclk);
    digital_in <= 16'h0002;
    repeat (10) @(posedge pclk);
    check("restart", {31'h0, regulator_active}, 32'h1);
    await("boost", 4, 1'b1, 30);
    await("slept", 0, 1'b0, 20);
    fb <= 16'sd50;
    await("fb_wake", 1, 1'b1, 20);
    run_order <= 1'b0;
    digital_in <= 16'h0000;
    await("stop2", 0, 1'b0, 20);
  endtask
  task automatic t_reverse;
    apb(1'b1, psw_pkg::A_SLEEP, 32'h0002_0000);
    apb(1'b1, psw_pkg::A_BOOST, 32'h0000_0032);
    apb(1'b1, psw_pkg::A_CTRL, 32'h0000_0027);
    ref_val <= 16'sd300;
    fb <= 16'sd310;
    reg_val <= 16'sd20;
    run_order <= 1'b1;
    repeat (20) @(posedge pclk);
    check("no_wake", {motor_run, 15'h0, freq_cmd}, 32'h0);
    fb <= 16'sd330;
    await("err_wake", 1, 1'b1, 20);
    fb <= 16'sd310;
    await("spd_sleep", 0, 1'b0, 20);
    check("no_boost", 32'(freq_cmd), 32'h0);
    run_order <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_warn();
    t_shunt();
    t_run();
    t_switch();
    t_reverse();
    print_verdict();
  end
endmodule // tb
